// ===== rtl/css_addr_gen.sv
// Purpose: Data address formation for a byte operand
// Assumes: Index base comes from the core's indirect pointer
// Notes:   Pure combinational
`timescale 1ns/100ps
module css_addr_gen
    import css_pkg::*;
(
    // Operand
    input  wire logic [7:0]  operand_in,
    input  wire logic        access_sel_in,
    // Context
    input  wire logic [3:0]  bank_select_register_in,
    input  wire logic        ext_set_en_in,
    input  wire logic [11:0] index_base_in,
    // Result
    output css_pkg::css_amode_t mode_out,
    output logic [11:0]         addr_out
);
    always_comb
    begin
        if (access_sel_in)
        begin
            mode_out = CSS_AM_BANKED;
            addr_out = {bank_select_register_in, operand_in};
        end
        else if (ext_set_en_in && (operand_in <= CSS_ILO_MAX))
        begin
            mode_out = CSS_AM_INDEX;
            addr_out = index_base_in + {4'h0, operand_in};
        end
        else if (operand_in < CSS_ACCESS_SPLIT)
        begin
            mode_out = CSS_AM_ACCESS;
            addr_out = {4'h0, operand_in};
        end
        else
        begin
            mode_out = CSS_AM_ACCESS;
            addr_out = {CSS_ACCESS_HI_BNK, operand_in};
        end
    end
endmodule

// ===== rtl/css_exec.sv
// Purpose: Execute compare-with-working-register-and-skip instructions
// Assumes: Fetch holds the instruction stable for a whole Q1..Q4 cycle
// Notes:   Data byte is returned combinationally by Q3
`timescale 1ns/100ps
// Functional notes
// - Greater compare skips only when data byte is unsigned strictly above working register
// - Taken skip discards the fetched instruction and runs no-operation cycles instead
// - One cycle without skip, two cycles with skip over a one-word instruction
// - Access bit 0 selects shared access bank, 1 uses bank select register
// - Indexed literal offset when extended set on, access bit 0, operand at most 95
// - Equal compare skips when data byte equals working register
// - Skip over two-word instruction costs three cycles, three-word costs four
module css_exec
    import css_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk_in,
    input  wire logic               nrst_in,
    // Instruction
    input  css_pkg::css_instr_t     instr_in,
    // Core context
    input  wire logic [7:0]         working_register_in,
    input  wire logic [3:0]         bank_select_register_in,
    input  wire logic               ext_set_en_in,
    input  wire logic [11:0]        index_base_in,
    // Data memory
    input  wire logic [7:0]         data_byte_in,
    output css_pkg::css_dreq_t      dreq_out,
    // Outcome
    output css_pkg::css_result_t    result_out,
    output logic [1:0]              phase_out,
    output logic                    nop_active_out,
    output logic                    pc_advance_out,
    output logic                    status_we_out
);
    typedef struct packed {
        logic [1:0]  phase;
        logic [1:0]  flush;
        logic        gt_op;
        logic        eq_op;
        logic        hit;
        css_dreq_t   dreq;
        css_result_t res;
    } css_state_t;

    css_state_t  st_ff;
    css_state_t  nxt_st;
    css_amode_t  amode;
    logic [11:0] addr;
    logic        is_gt;
    logic        is_eq;
    logic        cond;

    css_addr_gen u_addr
    (
        .operand_in              (instr_in.word[7:0]),
        .access_sel_in           (instr_in.word[8]),
        .bank_select_register_in (bank_select_register_in),
        .ext_set_en_in           (ext_set_en_in),
        .index_base_in           (index_base_in),
        .mode_out                (amode),
        .addr_out                (addr)
    );

    assign is_gt = instr_in.valid && (instr_in.word[15:9] == CSS_OP_GT);
    assign is_eq = instr_in.valid && (instr_in.word[15:9] == CSS_OP_EQ);
    always_comb
    begin
        cond = 1'b0;
        if (st_ff.gt_op)
        begin
            cond = data_byte_in > working_register_in;
        end
        else if (st_ff.eq_op)
        begin
            cond = data_byte_in == working_register_in;
        end
    end

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.phase = st_ff.phase + 2'h1;
        nxt_st.res.done = 1'b0;
        nxt_st.dreq.rd = 1'b0;
        unique case (st_ff.phase)
            CSS_PH_Q1:
            begin
                if (st_ff.flush == CSS_RST_FLUSH)
                begin
                    nxt_st.gt_op = is_gt;
                    nxt_st.eq_op = is_eq;
                    nxt_st.hit = 1'b0;
                    nxt_st.dreq.rd = is_gt || is_eq;
                    nxt_st.dreq.addr = addr;
                    nxt_st.dreq.mode = amode;
                end
            end
            CSS_PH_Q2:
            begin
                nxt_st.dreq.rd = st_ff.dreq.rd;
            end
            CSS_PH_Q3:
            begin
                if (st_ff.gt_op || st_ff.eq_op)
                begin
                    nxt_st.hit = cond;
                end
            end
            CSS_PH_Q4:
            begin
                if (st_ff.flush != CSS_RST_FLUSH)
                begin
                    nxt_st.flush = st_ff.flush - 2'h1;
                end
                else if (st_ff.gt_op || st_ff.eq_op)
                begin
                    nxt_st.res.done = 1'b1;
                    nxt_st.res.skip = st_ff.hit;
                    nxt_st.res.flush_cycles = st_ff.hit ? instr_in.next_words : 2'h0;
                    nxt_st.flush = st_ff.hit ? instr_in.next_words : 2'h0;
                    nxt_st.gt_op = 1'b0;
                    nxt_st.eq_op = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign dreq_out       = st_ff.dreq;
    assign result_out     = st_ff.res;
    assign phase_out      = st_ff.phase;
    assign nop_active_out = st_ff.flush != CSS_RST_FLUSH;
    assign pc_advance_out = st_ff.phase == CSS_PH_Q4;
    assign status_we_out  = 1'b0;
endmodule

// ===== rtl/css_pkg.sv
// Purpose: Shared constants and carriers for the compare-and-skip execution block
// Assumes: 16-bit program words, 8-bit data, 12-bit data address
// Notes:   Four Q phases make one instruction cycle
package css_pkg;

    localparam int          CSS_CLK_MHZ       = 50;
    localparam int          CSS_Q_PHASES      = 4;
    localparam logic [6:0]  CSS_OP_GT         = 7'h32;
    localparam logic [6:0]  CSS_OP_EQ         = 7'h31;
    localparam logic [7:0]  CSS_ILO_MAX       = 8'h5F;
    localparam logic [7:0]  CSS_ACCESS_SPLIT  = 8'h60;
    localparam logic [3:0]  CSS_ACCESS_HI_BNK = 4'hF;
    localparam logic [1:0]  CSS_PH_Q1         = 2'h0;
    localparam logic [1:0]  CSS_PH_Q2         = 2'h1;
    localparam logic [1:0]  CSS_PH_Q3         = 2'h2;
    localparam logic [1:0]  CSS_PH_Q4         = 2'h3;
    localparam logic [1:0]  CSS_RST_PHASE     = 2'h0;
    localparam logic [1:0]  CSS_RST_FLUSH     = 2'h0;

    // Mode of data address formation
    typedef enum logic [1:0] {
        CSS_AM_ACCESS = 2'b00,
        CSS_AM_BANKED = 2'b01,
        CSS_AM_INDEX  = 2'b10
    } css_amode_t;

    // Instruction presented by fetch
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
        logic [1:0]  next_words;
    } css_instr_t;

    // Data memory read request
    typedef struct packed {
        logic        rd;
        logic [11:0] addr;
        css_amode_t  mode;
    } css_dreq_t;

    // Execution outcome
    typedef struct packed {
        logic       done;
        logic       skip;
        logic [1:0] flush_cycles;
    } css_result_t;

endpackage

// ===== verification/compare_skip_execution_bench.sv
// Purpose: Directed bench for compare-and-skip execution
// Assumes: Bank select 5, index base 0x200
// Notes:   Skip cost measured in no-op cycles
`timescale 1ns/100ps
module compare_skip_execution_bench;
    import css_pkg::*;
    logic        core_clk_in, nrst_in, ext_set_en_in, nop, pca, swe;
    logic [7:0]  w, d;
    logic [11:0] ibase;
    logic [3:0]  bank_select_register;
    logic [1:0]  ph;
    css_instr_t  instr;
    css_dreq_t   dreq;
    css_result_t res;
    int          miscompares = 0, n_compared = 0, cyc = 0;
    css_exec DUT (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .instr_in(instr),
        .working_register_in(w), .bank_select_register_in(bank_select_register), .ext_set_en_in(ext_set_en_in),
        .index_base_in(ibase), .data_byte_in(d), .dreq_out(dreq), .result_out(res),
        .phase_out(ph), .nop_active_out(nop), .pc_advance_out(pca), .status_we_out(swe));
    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1)
            miscompares++;
        if (ok !== 1'b1)
            $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic run(input logic [6:0] op, input logic a, input logic [7:0] f, wv, dv,
                       input logic [1:0] nw, input logic sk, input logic [11:0] ea);
        int n;
        int p;
        n = 0;
        do
        begin
            do @(negedge core_clk_in); while (ph !== CSS_PH_Q4);
            @(posedge core_clk_in);
            instr <= '{1'b1, {op, a, f}, nw};
            w     <= wv;
            d     <= dv;
            @(negedge core_clk_in);
        end
        while (nop !== 1'b0);
        repeat (2) @(negedge core_clk_in);
        chk(dreq.rd === 1'b1 && dreq.addr === ea, "read address");
        @(posedge core_clk_in);
        instr.valid <= 1'b0;
        while (res.done !== 1'b1 && n < 8)
        begin
            @(negedge core_clk_in);
            n++;
        end
        chk(res.done === 1'b1 && res.skip === sk && swe === 1'b0, "skip outcome");
        chk(res.flush_cycles === (sk ? nw : 2'h0), "flush count");
        n = 0;
        p = 0;
        repeat (16)
        begin
            n += (nop === 1'b1);
            p += (pca === 1'b1);
            @(negedge core_clk_in);
        end
        chk(n == (sk ? 4 * nw : 0), "no-op cycle count");
        chk(p == 16 / CSS_Q_PHASES, "pc advance count");
    endtask
    task automatic t_greater;
        run(CSS_OP_GT, 1'b1, 8'h12, 8'h7F, 8'h80, 2'h1, 1'b1, 12'h512);
        chk(dreq.mode === CSS_AM_BANKED, "banked mode");
        run(CSS_OP_GT, 1'b1, 8'h12, 8'h80, 8'h80, 2'h1, 1'b0, 12'h512);
        run(CSS_OP_GT, 1'b1, 8'h12, 8'hFF, 8'h00, 2'h1, 1'b0, 12'h512);
        run(CSS_OP_GT, 1'b1, 8'h12, 8'h00, 8'hFF, 2'h2, 1'b1, 12'h512);
        run(CSS_OP_GT, 1'b1, 8'h12, 8'h00, 8'hFF, 2'h3, 1'b1, 12'h512);
        $display("greater test done");
    endtask
    task automatic t_equal;
        run(CSS_OP_EQ, 1'b1, 8'h12, 8'h5A, 8'h5A, 2'h1, 1'b1, 12'h512);
        run(CSS_OP_EQ, 1'b1, 8'h12, 8'h5A, 8'h5B, 2'h1, 1'b0, 12'h512);
        $display("equal test done");
    endtask
    task automatic t_addr;
        run(CSS_OP_GT, 1'b0, 8'h5F, 8'h01, 8'h02, 2'h1, 1'b1, 12'h05F);
        chk(dreq.mode === CSS_AM_ACCESS, "access mode");
        @(posedge core_clk_in) ext_set_en_in <= 1'b1;
        run(CSS_OP_GT, 1'b0, 8'h5F, 8'h01, 8'h02, 2'h1, 1'b1, 12'h25F);
        chk(dreq.mode === CSS_AM_INDEX, "index mode");
        run(CSS_OP_GT, 1'b0, 8'h60, 8'h01, 8'h02, 2'h1, 1'b1, 12'hF60);
        chk(dreq.mode === CSS_AM_ACCESS, "upper access mode");
        $display("address test done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            wrap_up;
        end
    end
    initial
    begin
        nrst_in = 1'b0;
        instr = '0;
        w = 8'h00;
        d = 8'h00;
        bank_select_register = 4'h5;
        ibase = 12'h200;
        ext_set_en_in = 1'b0;
        repeat (8) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        @(negedge core_clk_in);
        chk(ph === 2'h0 && res === '0 && dreq === '0 && nop === 1'b0, "reset state");
        t_greater;
        t_equal;
        t_addr;
        wrap_up;
    end
endmodule

// ===== verification/css_exec_checker.sv
// Purpose: Port checks for compare-and-skip execution
// Assumes: Bound to css_exec
// Notes:   One clock domain
`timescale 1ns/100ps
module css_exec_checker
    import css_pkg::*;
(
    // Watched ports
    input wire logic            core_clk_in,
    input wire logic            nrst_in,
    input css_pkg::css_instr_t  instr_in,
    input wire logic [7:0]      working_register_in,
    input wire logic [7:0]      data_byte_in,
    input css_pkg::css_dreq_t   dreq_out,
    input css_pkg::css_result_t result_out,
    input wire logic [1:0]      phase_out,
    input wire logic            nop_active_out,
    input wire logic            status_we_out
);
    logic hit_ff;
    wire  op_gt = instr_in.word[15:9] == CSS_OP_GT;
    wire  op_eq = instr_in.word[15:9] == CSS_OP_EQ;
    wire  take  = phase_out == CSS_PH_Q1 && !nop_active_out && instr_in.valid && (op_gt || op_eq);
    // Outcome expected from the Q3 sample
    always_ff @(posedge core_clk_in or negedge nrst_in)
        if (!nrst_in)
            hit_ff <= 1'b0;
        else if (phase_out == CSS_PH_Q3)
            hit_ff <= op_gt ? data_byte_in > working_register_in
                            : data_byte_in == working_register_in;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    phase_step_a: assert property (1 |=> phase_out == $past(phase_out) + 2'h1)
        else $error("phase did not advance");
    done_lat_a: assert property (take |-> ##[4:5] result_out.done)
        else $error("no result after compare");
    read_req_a: assert property (take |-> ##[1:2] dreq_out.rd)
        else $error("no data read");
    skip_value_a: assert property (result_out.done |->
                                   result_out.skip == hit_ff)
        else $error("wrong skip decision");
    nop_fill_a: assert property (result_out.done && result_out.skip |->
                                 nop_active_out [*4])
        else $error("skip without no-op cycle");
    nop_clear_a: assert property (result_out.done && !result_out.skip |->
                                  !nop_active_out)
        else $error("no-op without skip");
    status_hold_a: assert property (status_we_out == 1'b0)
        else $error("status written");
    done_pulse_a: assert property (result_out.done |=> !result_out.done)
        else $error("result pulse too long");
    cover property (result_out.done && result_out.skip);
    cover property (result_out.done && !result_out.skip);
    cover property (take && op_eq);
endmodule
bind css_exec css_exec_checker u_chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .instr_in(instr_in), .working_register_in(working_register_in),
    .data_byte_in(data_byte_in), .dreq_out(dreq_out), .result_out(result_out),
    .phase_out(phase_out), .nop_active_out(nop_active_out), .status_we_out(status_we_out));
